// >>> sim/reset_cause_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none

module reset_cause_flags_tb;

    logic                       clk;
    logic                       rst;
    rcf_pkg::rcf_events_t       ev;
    logic                       stby;
    logic [rcf_pkg::ADDR_W-1:0] awaddr;
    logic                       awvalid;
    logic                       awready;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       wvalid;
    logic                       wready;
    logic [1:0]                 bresp;
    logic                       bvalid;
    logic                       bready;
    logic [rcf_pkg::ADDR_W-1:0] araddr;
    logic                       arvalid;
    logic                       arready;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       rvalid;
    logic                       rready;
    int                         err_total;
    int                         checks_done;
    logic [31:0]                acc;
    int                         bitpos [9] = '{0, 1, 2, 3, 4, 6, 7, 9, 29};

    rcf_reset_cause i_dut
    (
        .CLOCK_I          (clk),
        .RESET_I          (rst),
        .EVENTS_I         (ev),
        .REG_STANDBY_ON_O (stby),
        .S_AXI_AWADDR_I   (awaddr),
        .S_AXI_AWVALID_I  (awvalid),
        .S_AXI_AWREADY_O  (awready),
        .S_AXI_WDATA_I    (wdata),
        .S_AXI_WSTRB_I    (wstrb),
        .S_AXI_WVALID_I   (wvalid),
        .S_AXI_WREADY_O   (wready),
        .S_AXI_BRESP_O    (bresp),
        .S_AXI_BVALID_O   (bvalid),
        .S_AXI_BREADY_I   (bready),
        .S_AXI_ARADDR_I   (araddr),
        .S_AXI_ARVALID_I  (arvalid),
        .S_AXI_ARREADY_O  (arready),
        .S_AXI_RDATA_O    (rdata),
        .S_AXI_RRESP_O    (rresp),
        .S_AXI_RVALID_O   (rvalid),
        .S_AXI_RREADY_I   (rready)
    );

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Single comparison point, four-state safe
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic give_up();
        err_total++;
        $display("wrong value at %0t: bus gave no answer", $time);
        tally_and_finish();
    endtask

    // Handshakes are judged 1 ns after an edge, once everything settled
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        logic take_aw;
        logic take_w;
        logic got_b;
        int   n;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        got_b = 1'b0;
        n = 0;
        while (!got_b)
        begin
            #1;
            take_aw = awvalid && awready;
            take_w = wvalid && wready;
            got_b = bvalid && bready;
            if (got_b)
                check({30'h0000_0000, bresp}, {30'h0000_0000, er});
            @(posedge clk);
            if (take_aw)
                awvalid <= 1'b0;
            if (take_w)
                wvalid <= 1'b0;
            if (got_b)
                bready <= 1'b0;
            n++;
            if (n == 50)
                give_up();
        end
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed,
                            input logic [1:0] er);
        logic take_ar;
        logic got_r;
        int   n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        got_r = 1'b0;
        n = 0;
        while (!got_r)
        begin
            #1;
            take_ar = arvalid && arready;
            got_r = rvalid && rready;
            if (got_r)
            begin
                check(rdata, ed);
                check({30'h0000_0000, rresp}, {30'h0000_0000, er});
            end
            @(posedge clk);
            if (take_ar)
                arvalid <= 1'b0;
            if (got_r)
                rready <= 1'b0;
            n++;
            if (n == 50)
                give_up();
        end
    endtask

    // One-cycle cause pulse; index follows the event struct, lsb first
    task automatic fire(input int i);
        @(posedge clk);
        ev <= rcf_pkg::rcf_events_t'(9'h001 << i);
        @(posedge clk);
        ev <= '0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Main sequence
    initial
    begin
        rst = 1'b1;
        ev = '0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        err_total = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        axi_read(rcf_pkg::CAUSE_ADDR, rcf_pkg::RESET_VAL, 2'h0);
        check({31'h0000_0000, stby}, 32'h0000_0000);
        $display("test power-on done");
        axi_write(rcf_pkg::CAUSE_ADDR, 32'h0000_0000, 4'hF, 2'h0);
        axi_read(rcf_pkg::CAUSE_ADDR, 32'h0000_0000, 2'h0);
        axi_write(rcf_pkg::CAUSE_ADDR, 32'hFFFF_FFFF, 4'hF, 2'h0);
        axi_read(rcf_pkg::CAUSE_ADDR, 32'h0000_0100, 2'h0);
        check({31'h0000_0000, stby}, 32'h0000_0001);
        $display("test clear and write-ones done");
        acc = 32'h0000_0100;
        for (int i = 0; i < 9; i++)
        begin
            fire(i);
            acc = acc | (32'h0000_0001 << bitpos[i]);
            axi_read(rcf_pkg::CAUSE_ADDR, acc, 2'h0);
        end
        $display("test each cause done");
        // selective clear by zero bits and by byte strobes
        axi_write(rcf_pkg::CAUSE_ADDR, 32'hDFFF_FFFF, 4'hF, 2'h0);
        axi_read(rcf_pkg::CAUSE_ADDR, 32'h0000_03DF, 2'h0);
        axi_write(rcf_pkg::CAUSE_ADDR, 32'h0000_0000, 4'h1, 2'h0);
        axi_read(rcf_pkg::CAUSE_ADDR, 32'h0000_0300, 2'h0);
        $display("test partial clear done");
        // Unmapped word refused and harmless
        axi_write(4'h4, 32'h0000_0000, 4'hF, rcf_pkg::RESP_SLVERR);
        axi_read(rcf_pkg::CAUSE_ADDR, 32'h0000_0300, 2'h0);
        axi_read(4'h4, 32'h0000_0000, rcf_pkg::RESP_SLVERR);
        $display("test unmapped address done");
        do_reset();
        axi_read(rcf_pkg::CAUSE_ADDR, rcf_pkg::RESET_VAL, 2'h0);
        check({31'h0000_0000, stby}, 32'h0000_0000);
        $display("test second reset done");
        tally_and_finish();
    end

endmodule

`default_nettype wire

// >>> src/rcf_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none

// AXI4-Lite single-register slave port: accepts address and data in
// either order, gives one write strobe, answers reads from rd_data_i.
module rcf_axil_slave
(
    input  wire logic                      clock_i,
    input  wire logic                      reset_i,
    input  wire logic [rcf_pkg::ADDR_W-1:0] awaddr_i,
    input  wire logic                      awvalid_i,
    output logic                           awready_o,
    input  wire logic [31:0]               wdata_i,
    input  wire logic [3:0]                wstrb_i,
    input  wire logic                      wvalid_i,
    output logic                           wready_o,
    output logic [1:0]                     bresp_o,
    output logic                           bvalid_o,
    input  wire logic                      bready_i,
    input  wire logic [rcf_pkg::ADDR_W-1:0] araddr_i,
    input  wire logic                      arvalid_i,
    output logic                           arready_o,
    output logic [31:0]                    rdata_o,
    output logic [1:0]                     rresp_o,
    output logic                           rvalid_o,
    input  wire logic                      rready_i,
    output logic                           wr_en_o,
    output logic [31:0]                    wr_data_o,
    output logic [3:0]                     wr_strb_o,
    input  wire logic [31:0]               rd_data_i
);

    logic                      aw_full_q;
    logic [rcf_pkg::ADDR_W-1:0] aw_addr_q;
    logic                      w_full_q;
    logic [31:0]               w_data_q;
    logic [3:0]                w_strb_q;
    logic                      do_write;

    // Each channel holds one item until the response is taken
    assign awready_o = !aw_full_q && !bvalid_o;
    assign wready_o  = !w_full_q && !bvalid_o;
    assign arready_o = !rvalid_o;
    assign do_write  = aw_full_q && w_full_q && !bvalid_o;

    // Write strobe to the register file
    assign wr_en_o   = do_write && (aw_addr_q == rcf_pkg::CAUSE_ADDR);
    assign wr_data_o = w_data_q;
    assign wr_strb_o = w_strb_q;

    // Write address and data capture
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (awvalid_i && awready_o)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= awaddr_i;
            end
            else if (do_write)
                aw_full_q <= 1'b0;
            if (wvalid_i && wready_o)
            begin
                w_full_q <= 1'b1;
                w_data_q <= wdata_i;
                w_strb_q <= wstrb_i;
            end
            else if (do_write)
                w_full_q <= 1'b0;
        end
    end

    // Write response; unmapped addresses get SLVERR
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            bvalid_o <= 1'b0;
            bresp_o  <= rcf_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_o <= 1'b1;
            bresp_o  <= (aw_addr_q == rcf_pkg::CAUSE_ADDR) ?
                        rcf_pkg::RESP_OKAY : rcf_pkg::RESP_SLVERR;
        end
        else if (bready_i)
            bvalid_o <= 1'b0;
    end

    // Read channel, one cycle after the address is taken
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rvalid_o <= 1'b0;
            rdata_o  <= 32'h0000_0000;
            rresp_o  <= rcf_pkg::RESP_OKAY;
        end
        else if (arvalid_i && arready_o)
        begin
            rvalid_o <= 1'b1;
            if (araddr_i == rcf_pkg::CAUSE_ADDR)
            begin
                rdata_o <= rd_data_i;
                rresp_o <= rcf_pkg::RESP_OKAY;
            end
            else
            begin
                rdata_o <= 32'h0000_0000;
                rresp_o <= rcf_pkg::RESP_SLVERR;
            end
        end
        else if (rready_i)
            rvalid_o <= 1'b0;
    end

endmodule

`default_nettype wire

// >>> src/rcf_pkg.sv
package rcf_pkg;

    // Register map, byte addresses
    localparam logic [3:0] CAUSE_ADDR = 4'h0;
    localparam int unsigned ADDR_W = 4;

    // Field positions inside the reset cause register
    localparam int unsigned HV_BIT    = 29;
    localparam int unsigned CMR_BIT   = 9;
    localparam int unsigned VREG_BIT  = 8;
    localparam int unsigned PIN_BIT   = 7;
    localparam int unsigned SW_BIT    = 6;
    localparam int unsigned WDT_BIT   = 4;
    localparam int unsigned SLEEP_BIT = 3;
    localparam int unsigned IDLE_BIT  = 2;
    localparam int unsigned BO_BIT    = 1;
    localparam int unsigned POR_BIT   = 0;

    // Implemented bits and the power-on value
    localparam logic [31:0] IMPL_MASK  = 32'h2000_03DF;
    localparam logic [31:0] FLAG_MASK  = 32'h2000_02DF;
    localparam logic [31:0] RESET_VAL  = 32'h0000_0003;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Hardware cause events, one-cycle pulses
    typedef struct packed {
        logic high_voltage_detect;
        logic config_mismatch;
        logic master_clear_pin;
        logic software_reset;
        logic watchdog_timeout;
        logic sleep_wake;
        logic idle_wake;
        logic brownout;
        logic power_on;
    } rcf_events_t;

endpackage

// >>> src/rcf_reset_cause.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - High-voltage detect sets bit 29; clear otherwise.
// R2 - Configuration mismatch reset sets bit 9.
// R3 - Bit 8 keeps regulator on in Sleep when 1; resets to 0.
// R4 - Master clear pin reset sets bit 7.
// R5 - Software reset sets bit 6.
// R6 - Watchdog time-out sets bit 4.
// R7 - Wake from Sleep sets bit 3.
// R8 - Wake from Idle sets bit 2.
// R9 - Brown-out sets bit 1; reads 1 after power-on.
// R10 - Power-on sets bit 0; reads 1 after power-on, others but bit 1 read 0.
// R11 - Flags set only by hardware, cleared by software writing 0.
// R12 - Software clears brown-out and power-on flags after reading.
// R13 - Bits 31-30, 28-10 and 5 read 0, ignore writes.
// R14 - New causes add to flags already set.
module rcf_reset_cause
(
    input  wire logic                       CLOCK_I,
    input  wire logic                       RESET_I,
    input  wire rcf_pkg::rcf_events_t       EVENTS_I,
    output logic                            REG_STANDBY_ON_O,
    input  wire logic [rcf_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic                       S_AXI_AWVALID_I,
    output logic                            S_AXI_AWREADY_O,
    input  wire logic [31:0]                S_AXI_WDATA_I,
    input  wire logic [3:0]                 S_AXI_WSTRB_I,
    input  wire logic                       S_AXI_WVALID_I,
    output logic                            S_AXI_WREADY_O,
    output logic [1:0]                      S_AXI_BRESP_O,
    output logic                            S_AXI_BVALID_O,
    input  wire logic                       S_AXI_BREADY_I,
    input  wire logic [rcf_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic                       S_AXI_ARVALID_I,
    output logic                            S_AXI_ARREADY_O,
    output logic [31:0]                     S_AXI_RDATA_O,
    output logic [1:0]                      S_AXI_RRESP_O,
    output logic                            S_AXI_RVALID_O,
    input  wire logic                       S_AXI_RREADY_I
);

    logic        wr_en;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [31:0] cause_q;
    logic [31:0] cause_d;
    logic [31:0] set_vec;
    logic [31:0] wr_mask;
    logic [31:0] rd_data;

    // Expand byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    rcf_axil_slave u_bus
    (
        .clock_i   (CLOCK_I),
        .reset_i   (RESET_I),
        .awaddr_i  (S_AXI_AWADDR_I),
        .awvalid_i (S_AXI_AWVALID_I),
        .awready_o (S_AXI_AWREADY_O),
        .wdata_i   (S_AXI_WDATA_I),
        .wstrb_i   (S_AXI_WSTRB_I),
        .wvalid_i  (S_AXI_WVALID_I),
        .wready_o  (S_AXI_WREADY_O),
        .bresp_o   (S_AXI_BRESP_O),
        .bvalid_o  (S_AXI_BVALID_O),
        .bready_i  (S_AXI_BREADY_I),
        .araddr_i  (S_AXI_ARADDR_I),
        .arvalid_i (S_AXI_ARVALID_I),
        .arready_o (S_AXI_ARREADY_O),
        .rdata_o   (S_AXI_RDATA_O),
        .rresp_o   (S_AXI_RRESP_O),
        .rvalid_o  (S_AXI_RVALID_O),
        .rready_i  (S_AXI_RREADY_I),
        .wr_en_o   (wr_en),
        .wr_data_o (wr_data),
        .wr_strb_o (wr_strb),
        .rd_data_i (rd_data)
    );

    // Map event pulses onto their flag positions
    always_comb
    begin
        set_vec = 32'h0000_0000;
        // R1 high voltage
        set_vec[rcf_pkg::HV_BIT]    = EVENTS_I.high_voltage_detect;
        // R2 config mismatch
        set_vec[rcf_pkg::CMR_BIT]   = EVENTS_I.config_mismatch;
        // R4 pin reset
        set_vec[rcf_pkg::PIN_BIT]   = EVENTS_I.master_clear_pin;
        // R5 software reset
        set_vec[rcf_pkg::SW_BIT]    = EVENTS_I.software_reset;
        // R6 watchdog
        set_vec[rcf_pkg::WDT_BIT]   = EVENTS_I.watchdog_timeout;
        // R7 sleep wake
        set_vec[rcf_pkg::SLEEP_BIT] = EVENTS_I.sleep_wake;
        // R8 idle wake
        set_vec[rcf_pkg::IDLE_BIT]  = EVENTS_I.idle_wake;
        // R9 brown-out
        set_vec[rcf_pkg::BO_BIT]    = EVENTS_I.brownout;
        // R10 power-on
        set_vec[rcf_pkg::POR_BIT]   = EVENTS_I.power_on;
    end

    // Write mask limited to implemented bits
    // R13 ignore unimplemented
    assign wr_mask = wr_en ? (strb_mask(wr_strb) & rcf_pkg::IMPL_MASK)
                           : 32'h0000_0000;

    // Next value: flags only clear by a 0 write, set always wins.
    // A 1 written to a flag cannot fake an event.
    always_comb
    begin
        cause_d = cause_q;
        // R11 software clears flags
        cause_d = cause_d & ~(wr_mask & rcf_pkg::FLAG_MASK & ~wr_data);
        // R3 standby control is plain read/write
        cause_d[rcf_pkg::VREG_BIT] = wr_mask[rcf_pkg::VREG_BIT] ?
                                     wr_data[rcf_pkg::VREG_BIT] :
                                     cause_q[rcf_pkg::VREG_BIT];
        // R14 accumulate causes
        cause_d = cause_d | (set_vec & rcf_pkg::FLAG_MASK);
    end

    // Cause register; power-on value has brown-out and power-on set
    always_ff @(posedge CLOCK_I)
    begin
        // R10 power-on value
        if (RESET_I)
            cause_q <= rcf_pkg::RESET_VAL;
        else
            cause_q <= cause_d;
    end

    // R13 read zeros in gaps
    assign rd_data = cause_q & rcf_pkg::IMPL_MASK;

    // R3 regulator control
    assign REG_STANDBY_ON_O = cause_q[rcf_pkg::VREG_BIT];

    // Checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);

    AST_HV_SET: assert property ( // R1
        EVENTS_I.high_voltage_detect |=> cause_q[rcf_pkg::HV_BIT])
        else $error("high-voltage flag not set");
    AST_CMR_SET: assert property ( // R2
        EVENTS_I.config_mismatch |=> cause_q[rcf_pkg::CMR_BIT])
        else $error("config mismatch flag not set");
    AST_VREG_WR: assert property ( // R3
        wr_en && wr_strb[1] |=>
        REG_STANDBY_ON_O == $past(wr_data[rcf_pkg::VREG_BIT]))
        else $error("standby control not written");
    AST_PIN_SET: assert property ( // R4
        EVENTS_I.master_clear_pin |=> cause_q[rcf_pkg::PIN_BIT])
        else $error("pin reset flag not set");
    AST_SW_SET: assert property ( // R5
        EVENTS_I.software_reset |=> cause_q[rcf_pkg::SW_BIT])
        else $error("software reset flag not set");
    AST_WDT_SET: assert property ( // R6
        EVENTS_I.watchdog_timeout |=> cause_q[rcf_pkg::WDT_BIT])
        else $error("watchdog flag not set");
    AST_SLEEP_SET: assert property ( // R7
        EVENTS_I.sleep_wake |=> cause_q[rcf_pkg::SLEEP_BIT])
        else $error("sleep flag not set");
    AST_IDLE_SET: assert property ( // R8
        EVENTS_I.idle_wake |=> cause_q[rcf_pkg::IDLE_BIT])
        else $error("idle flag not set");
    AST_BO_SET: assert property ( // R9
        EVENTS_I.brownout |=> cause_q[rcf_pkg::BO_BIT])
        else $error("brown-out flag not set");
    AST_POR_SET: assert property ( // R10
        EVENTS_I.power_on |=> cause_q[rcf_pkg::POR_BIT])
        else $error("power-on flag not set");
    AST_FLAG_HOLD: assert property ( // R11
        !wr_en |=> (($past(cause_q) & rcf_pkg::FLAG_MASK) &
                    ~cause_q) == 32'h0000_0000)
        else $error("flag dropped without write");
    AST_NO_SW_SET: assert property ( // R11
        (set_vec & rcf_pkg::FLAG_MASK) == 32'h0000_0000 |=>
        ((cause_q & ~$past(cause_q)) & rcf_pkg::FLAG_MASK)
            == 32'h0000_0000)
        else $error("flag set without event");
    AST_GAPS_ZERO: assert property ( // R13
        (rd_data & ~rcf_pkg::IMPL_MASK) == 32'h0000_0000 ##1
        (cause_q & ~rcf_pkg::IMPL_MASK) == 32'h0000_0000)
        else $error("unimplemented bit nonzero");
    AST_ACCUM: assert property ( // R14
        EVENTS_I.watchdog_timeout && cause_q[rcf_pkg::POR_BIT] && !wr_en
        |=> cause_q[rcf_pkg::POR_BIT] && cause_q[rcf_pkg::WDT_BIT])
        else $error("earlier flag lost");

    COV_CLEAR: cover property (wr_en ##1 cause_q[rcf_pkg::POR_BIT] == 1'b0);
    COV_WDT: cover property (EVENTS_I.watchdog_timeout ##1 S_AXI_RVALID_O);
    COV_VREG: cover property ($rose(REG_STANDBY_ON_O));
    COV_RACE: cover property (wr_en && EVENTS_I.brownout);

endmodule

`default_nettype wire
